// *** logic/bx_execute.sv ***
// Purpose: Executes conditional branches and bit operations on flags, operand, PC and I/O.
// Assumes: Software loads operand, flags and PC, then writes an instruction word to start.
// Notes:   All register writes are ignored while an instruction runs; an instruction write also sets the reject bit.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`default_nettype none
module bx_execute
    import bx_pkg::*;
#(
    parameter int PC_W = 16
)(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   busy,
    output bx_status_flag_register_t               statusFlags,
    output logic      [PC_W-1:0]   progCounter
);

    if (PC_W < 8 || PC_W > 32) begin : g_bad_pc
        $error("PC_W must lie between 8 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    bx_state_t           stateQ,    stateD;
    bx_instr_t           instrQ,    instrD;
    bx_status_flag_register_t            flagsQ,    flagsD;
    logic [7:0]          operandQ,  operandD;
    logic [PC_W-1:0]     pcQ,       pcD;
    logic                takenQ,    takenD;
    logic                rejectQ,   rejectD;
    logic                illegalQ,  illegalD;
    logic                busyQ,     busyD;
    logic                ackQ,      ackD;
    logic [31:0]         datQ,      datD;
    logic [7:0]          ioMem [IO_WORDS];
    logic                ioWrEn;
    logic [4:0]          ioWrAddr;
    logic [7:0]          ioWrData;
    logic [7:0]          flagVec;
    logic                cond;
    logic                isBranch;
    logic [PC_W-1:0]     offsetExt;
    logic [PC_W-1:0]     pcNext;
    logic [PC_W-1:0]     pcTarget;
    logic                selBit;
    logic                busReq;
    logic                busWr;
    logic [4:0]          ioIdx;
    bx_shift_t           sh;

    assign busReq    = wb_cyc_i & wb_stb_i;
    assign busWr     = busReq & wb_we_i & ackQ;
    assign ioIdx     = wb_adr_i[6:2];
    assign flagVec   = flagsQ;
    assign selBit    = operandQ[instrQ.bitSel];
    assign offsetExt = {{(PC_W-7){instrQ.offset[6]}}, instrQ.offset};
    assign pcNext    = pcQ + PC_W'(1);
    assign pcTarget  = pcQ + offsetExt + PC_W'(1);
    assign isBranch  = (instrQ.op <= OP_BRANCH_SIGNED_LT);

    bx_shift_unit u_shift (
        .op      (instrQ.op),
        .value   (operandQ),
        .carryIn (flagsQ.c),
        .res     (sh)
    );

    function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // The three-bit bitSel field selects the flag under test, so every single-flag branch shares one path.
    always_comb begin
        unique case (instrQ.op)
            OP_BRANCH_FLAG_SET:   cond = flagVec[instrQ.bitSel];
            OP_BRANCH_FLAG_CLEAR: cond = ~flagVec[instrQ.bitSel];
            OP_BRANCH_SIGNED_GE:  cond = ~(flagsQ.n ^ flagsQ.v);
            OP_BRANCH_SIGNED_LT:  cond = flagsQ.n ^ flagsQ.v;
            default:              cond = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] w;
        logic [7:0]  fv;
        w        = '0;
        fv       = flagVec;
        stateD   = stateQ;
        instrD   = instrQ;
        flagsD   = flagsQ;
        operandD = operandQ;
        pcD      = pcQ;
        takenD   = takenQ;
        rejectD  = rejectQ;
        illegalD = illegalQ;
        ioWrEn   = 1'b0;
        ioWrAddr = instrQ.ioAddr;
        ioWrData = ioMem[instrQ.ioAddr];
        unique case (stateQ)
            ST_IDLE: begin
                if (busWr) begin
                    unique case (wb_adr_i)
                        ADR_INSTR: begin
                            w        = mergeSel(32'(instrQ), wb_dat_i, wb_sel_i);
                            instrD   = bx_instr_t'(w[19:0]);
                            stateD   = ST_EXEC;
                            rejectD  = 1'b0;
                            illegalD = 1'b0;
                        end
                        ADR_OPERAND: begin
                            w        = mergeSel(32'(operandQ), wb_dat_i, wb_sel_i);
                            operandD = w[7:0];
                        end
                        ADR_FLAGS: begin
                            w      = mergeSel(32'(flagsQ), wb_dat_i, wb_sel_i);
                            flagsD = bx_status_flag_register_t'(w[7:0]);
                        end
                        ADR_PC: begin
                            w   = mergeSel(32'(pcQ), wb_dat_i, wb_sel_i);
                            pcD = w[PC_W-1:0];
                        end
                        default: begin
                            if (wb_adr_i >= ADR_IO_BASE && wb_sel_i[0]) begin
                                ioWrEn   = 1'b1;
                                ioWrAddr = ioIdx;
                                ioWrData = wb_dat_i[7:0];
                            end
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                stateD = ST_IDLE;
                pcD    = pcNext;
                if (isBranch) begin
                    takenD = cond;
                    if (cond) begin
                        stateD = ST_FINISH;
                        pcD    = pcQ;
                    end
                end else begin
                    takenD = 1'b0;
                    unique case (instrQ.op)
                        OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
                            stateD = ST_FINISH;
                            pcD    = pcQ;
                        end
                        OP_LOGICAL_SHIFT_L, OP_LOGICAL_SHIFT_R, OP_ARITH_SHIFT_R,
                        OP_ROTATE_LEFT_C, OP_ROTATE_RIGHT_C, OP_NIBBLE_SWAP: begin
                            operandD = sh.result;
                            if (sh.updFlags) begin
                                flagsD.c = sh.c;
                                flagsD.z = sh.z;
                                flagsD.n = sh.n;
                                flagsD.v = sh.v;
                            end
                        end
                        OP_FLAG_SET, OP_FLAG_CLEAR: begin
                            fv[instrQ.bitSel] = (instrQ.op == OP_FLAG_SET);
                            flagsD = bx_status_flag_register_t'(fv);
                        end
                        OP_BIT_TO_TRANSFER: begin
                            flagsD.t = selBit;
                        end
                        OP_TRANSFER_TO_BIT: begin
                            operandD[instrQ.bitSel] = flagsQ.t;
                        end
                        default: begin
                            illegalD = 1'b1;
                        end
                    endcase
                end
            end
            ST_FINISH: begin
                stateD = ST_IDLE;
                if (isBranch) begin
                    pcD = pcTarget;
                end else begin
                    pcD    = pcNext;
                    ioWrEn = 1'b1;
                    ioWrData[instrQ.bitSel] = (instrQ.op == OP_IO_BIT_SET);
                end
            end
            default: begin
                stateD = ST_IDLE;
            end
        endcase
        if (busWr && wb_adr_i == ADR_INSTR && stateQ != ST_IDLE) begin
            rejectD = 1'b1;
        end
        busyD = (stateD != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is captured with the acknowledge, so it is stable while ack is high.
    always_comb begin
        ackD = busReq & ~ackQ;
        datD = datQ;
        if (busReq && !ackQ) begin
            datD = '0;
            unique case (wb_adr_i)
                ADR_INSTR:   datD = 32'(instrQ);
                ADR_OPERAND: datD = 32'(operandQ);
                ADR_FLAGS:   datD = 32'(flagsQ);
                ADR_PC:      datD = 32'(pcQ);
                ADR_STATUS:  datD = {28'h0000000, illegalQ, rejectQ, takenQ, busyQ};
                default: begin
                    if (wb_adr_i >= ADR_IO_BASE) begin
                        datD = 32'(ioMem[ioIdx]);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stateQ   <= ST_IDLE;
            instrQ   <= '0;
            flagsQ   <= bx_status_flag_register_t'(FLAGS_RST);
            operandQ <= OPERAND_RST;
            pcQ      <= '0;
            takenQ   <= 1'b0;
            rejectQ  <= 1'b0;
            illegalQ <= 1'b0;
            busyQ    <= 1'b0;
            ackQ     <= 1'b0;
            datQ     <= '0;
            for (int i = 0; i < IO_WORDS; i++) begin
                ioMem[i] <= IO_RST;
            end
        end else if (clkEn) begin
            stateQ   <= stateD;
            instrQ   <= instrD;
            flagsQ   <= flagsD;
            operandQ <= operandD;
            pcQ      <= pcD;
            takenQ   <= takenD;
            rejectQ  <= rejectD;
            illegalQ <= illegalD;
            busyQ    <= busyD;
            ackQ     <= ackD;
            datQ     <= datD;
            if (ioWrEn) begin
                ioMem[ioWrAddr] <= ioWrData;
            end
        end
    end

    assign wb_ack_o    = ackQ;
    assign wb_dat_o    = datQ;
    assign busy        = busyQ;
    assign statusFlags = flagsQ;
    assign progCounter = pcQ;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    logic execFire;
    assign execFire = clkEn && stateQ == ST_EXEC;

    property p_carry_branch;
        execFire && instrQ.op == OP_BRANCH_FLAG_SET && instrQ.bitSel == FLAG_C && flagsQ.c
            |=> stateQ == ST_FINISH && pcQ == $past(pcQ);
    endproperty
    a_carry_branch: assert property (p_carry_branch) else $error("carry branch not taken");

    property p_signed_ge_false;
        execFire && instrQ.op == OP_BRANCH_SIGNED_GE && (flagsQ.n ^ flagsQ.v)
            |=> stateQ == ST_IDLE && pcQ == $past(pcNext);
    endproperty
    a_signed_ge_false: assert property (p_signed_ge_false) else $error("ge branch wrong");

    sequence s_taken_start;
        execFire && isBranch && cond;
    endsequence
    sequence s_finish_step;
        clkEn && stateQ == ST_FINISH;
    endsequence
    property p_taken_target;
        s_taken_start ##1 s_finish_step |=> stateQ == ST_IDLE && pcQ == $past(pcTarget);
    endproperty
    a_taken_target: assert property (p_taken_target) else $error("taken target wrong");

    property p_branch_flags;
        execFire && isBranch |=> flagsQ == $past(flagsQ);
    endproperty
    a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags");

    sequence s_io_start;
        execFire && (instrQ.op == OP_IO_BIT_SET || instrQ.op == OP_IO_BIT_CLEAR);
    endsequence
    property p_io_two_cycles;
        s_io_start ##1 clkEn |=> stateQ == ST_IDLE && flagsQ == $past(flagsQ, 2);
    endproperty
    a_io_two_cycles: assert property (p_io_two_cycles) else $error("io bit timing wrong");

    property p_shift_left;
        execFire && instrQ.op == OP_LOGICAL_SHIFT_L
            |=> operandQ == {$past(operandQ[6:0]), 1'b0} && flagsQ.c == $past(operandQ[7])
                && flagsQ.v == (operandQ[7] ^ flagsQ.c);
    endproperty
    a_shift_left: assert property (p_shift_left) else $error("shift left wrong");

    property p_rotate_right;
        execFire && instrQ.op == OP_ROTATE_RIGHT_C
            |=> operandQ == {$past(flagsQ.c), $past(operandQ[7:1])}
                && flagsQ.c == $past(operandQ[0]);
    endproperty
    a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong");

    property p_bit_store;
        execFire && instrQ.op == OP_BIT_TO_TRANSFER
            |=> flagsQ.t == $past(selBit) && flagsQ.c == $past(flagsQ.c)
                && operandQ == $past(operandQ);
    endproperty
    a_bit_store: assert property (p_bit_store) else $error("bit store wrong");

    property p_swap;
        execFire && instrQ.op == OP_NIBBLE_SWAP
            |=> operandQ == {$past(operandQ[3:0]), $past(operandQ[7:4])}
                && flagsQ == $past(flagsQ);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

    property p_flag_clear;
        execFire && instrQ.op == OP_FLAG_CLEAR && instrQ.bitSel == FLAG_I
            |=> !flagsQ.i && flagsQ.c == $past(flagsQ.c) && flagsQ.t == $past(flagsQ.t);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear wrong");

endmodule
`default_nettype wire

// *** logic/bx_pkg.sv ***
// Purpose: Shared constants and types of the branch and bit-operation execute block.
// Assumes: A classic Wishbone slave with 32-bit data and byte addresses.
// Notes:   Status flags are packed with the interrupt enable on top and carry at bit 0.
`default_nettype none
package bx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int          ADR_W         = 8;
    localparam logic [7:0]  ADR_INSTR     = 8'h00;
    localparam logic [7:0]  ADR_OPERAND   = 8'h04;
    localparam logic [7:0]  ADR_FLAGS     = 8'h08;
    localparam logic [7:0]  ADR_PC        = 8'h0C;
    localparam logic [7:0]  ADR_STATUS    = 8'h10;
    localparam logic [7:0]  ADR_IO_BASE   = 8'h80;
    localparam int          IO_WORDS      = 32;

    localparam logic [2:0]  FLAG_C        = 3'h0;
    localparam logic [2:0]  FLAG_Z        = 3'h1;
    localparam logic [2:0]  FLAG_N        = 3'h2;
    localparam logic [2:0]  FLAG_V        = 3'h3;
    localparam logic [2:0]  FLAG_S        = 3'h4;
    localparam logic [2:0]  FLAG_H        = 3'h5;
    localparam logic [2:0]  FLAG_T        = 3'h6;
    localparam logic [2:0]  FLAG_I        = 3'h7;

    localparam logic [7:0]  FLAGS_RST     = 8'h00;
    localparam logic [7:0]  OPERAND_RST   = 8'h00;
    localparam logic [7:0]  IO_RST        = 8'h00;

    localparam int          BRANCH_TAKEN_CYCLES = 2;
    localparam int          IO_BIT_CYCLES       = 2;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        OP_BRANCH_FLAG_SET   = 5'h00,
        OP_BRANCH_FLAG_CLEAR = 5'h01,
        OP_BRANCH_SIGNED_GE  = 5'h02,
        OP_BRANCH_SIGNED_LT  = 5'h03,
        OP_IO_BIT_SET        = 5'h04,
        OP_IO_BIT_CLEAR      = 5'h05,
        OP_LOGICAL_SHIFT_L   = 5'h06,
        OP_LOGICAL_SHIFT_R   = 5'h07,
        OP_ARITH_SHIFT_R     = 5'h08,
        OP_ROTATE_LEFT_C     = 5'h09,
        OP_ROTATE_RIGHT_C    = 5'h0A,
        OP_NIBBLE_SWAP       = 5'h0B,
        OP_FLAG_SET          = 5'h0C,
        OP_FLAG_CLEAR        = 5'h0D,
        OP_BIT_TO_TRANSFER   = 5'h0E,
        OP_TRANSFER_TO_BIT   = 5'h0F
    } bx_op_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_EXEC   = 3'b010,
        ST_FINISH = 3'b100
    } bx_state_t;

    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } bx_status_flag_register_t;

    typedef struct packed {
        logic [4:0] ioAddr;
        logic [6:0] offset;
        logic [2:0] bitSel;
        logic [4:0] op;
    } bx_instr_t;

    typedef struct packed {
        logic [7:0] result;
        logic       updFlags;
        logic       c;
        logic       v;
        logic       n;
        logic       z;
    } bx_shift_t;

endpackage
`default_nettype wire

// *** logic/bx_shift_unit.sv ***
// Purpose: Combinational shift, rotate and nibble-swap unit with its flag results.
// Assumes: Operand and carry come from registers; the caller decides when to commit.
// Notes:   Overflow is negative XOR carry after the shift, as for every shift here.
`timescale 1ns/1ns
`default_nettype none
module bx_shift_unit
    import bx_pkg::*;
(
    input  wire logic [4:0] op,
    input  wire logic [7:0] value,
    input  wire logic       carryIn,
    output bx_shift_t       res
);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        res = '0;
        res.updFlags = 1'b1;
        res.c = carryIn;
        unique case (op)
            OP_LOGICAL_SHIFT_L: begin
                res.result = {value[6:0], 1'b0};
                res.c = value[7];
            end
            OP_LOGICAL_SHIFT_R: begin
                res.result = {1'b0, value[7:1]};
                res.c = value[0];
            end
            OP_ARITH_SHIFT_R: begin
                res.result = {value[7], value[7:1]};
                res.c = value[0];
            end
            OP_ROTATE_LEFT_C: begin
                res.result = {value[6:0], carryIn};
                res.c = value[7];
            end
            OP_ROTATE_RIGHT_C: begin
                res.result = {carryIn, value[7:1]};
                res.c = value[0];
            end
            OP_NIBBLE_SWAP: begin
                res.result = {value[3:0], value[7:4]};
                res.updFlags = 1'b0;
            end
            default: begin
                res.result = value;
                res.updFlags = 1'b0;
            end
        endcase
        res.n = res.result[7];
        res.z = (res.result == 8'h00);
        res.v = res.n ^ res.c;
    end

endmodule
`default_nettype wire

// *** sim/bx_wb_model.sv ***
// Purpose: Classic Wishbone master standing for the core side of the execute block.
// Assumes: One access at a time; the bus is released for a cycle after every ack.
// Notes:   Waits here are unbounded; the bench watchdog cuts a hang short.
`timescale 1ns/1ns
`default_nettype none
module bx_wb_model
    import bx_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              ack,
    input  wire logic [31:0]       rdat,
    output logic                   cyc,
    output logic                   stb,
    output logic                   we,
    output logic      [ADR_W-1:0]  adr,
    output logic      [3:0]        sel,
    output logic      [31:0]       wdat
);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, adr, sel, wdat} = '0;
    end

    // Ack is read before this edge's updates land, so the sample is the one the slave meant.
    task automatic access(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge sys_clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        wdat <= ~d;
    endtask
endmodule
`default_nettype wire

// *** sim/tb_branch_and_bit_op_execute.sv ***
// Purpose: Self-checking bench for branches, shifts, flag and bit operations.
// Assumes: Operand, flags and PC are loaded over the bus before each random instruction; the clock-enable check loads only the PC.
// Notes:   The clock enable is dropped once, mid-instruction, to check that state freezes.
`timescale 1ns/1ns
`default_nettype none
module tb_branch_and_bit_op_execute
    import bx_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    logic              sysClk = 1'b0;
    logic              nrst;
    logic              clkEn = 1'b1;
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       wdat;
    logic [31:0]       rdat;
    logic              ack;
    logic              busy;
    bx_status_flag_register_t          flags;
    logic [15:0]       pc;
    logic [7:0]        ioModel [IO_WORDS];
    logic [31:0]       q;
    int                miscompares = 0;
    int                testsRun = 0;

    always #20 sysClk = ~sysClk;

    bx_execute #(.PC_W(16)) uut (.sys_clk(sysClk), .nrst(nrst), .clkEn(clkEn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .busy(busy), .statusFlags(flags), .progCounter(pc));

    bx_wb_model m (.sys_clk(sysClk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .wdat(wdat));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Flags are {i,t,h,s,v,n,z,c}; shifts leave the signed flag alone by design choice.
    function automatic void predict(input logic [4:0] op, input logic [2:0] ix,
        input logic [6:0] k, input logic [7:0] f, input logic [7:0] v, input logic [15:0] p,
        output logic [7:0] ef, output logic [7:0] ev, output logic [15:0] ep, output int cy);
        logic       tk;
        logic [8:0] s;
        ef = f;
        ev = v;
        ep = p + 16'h0001;
        cy = 1;
        tk = 1'b0;
        s = {f[0], v};
        case (op)
            5'h00: tk = f[ix];
            5'h01: tk = !f[ix];
            5'h02: tk = !(f[2] ^ f[3]);
            5'h03: tk = f[2] ^ f[3];
            5'h04, 5'h05: cy = 2;
            5'h06: s = {v, 1'b0};
            5'h07: s = {v[0], 1'b0, v[7:1]};
            5'h08: s = {v[0], v[7], v[7:1]};
            5'h09: s = {v, f[0]};
            5'h0A: s = {v[0], f[0], v[7:1]};
            5'h0B: ev = {v[3:0], v[7:4]};
            5'h0C: ef[ix] = 1'b1;
            5'h0D: ef[ix] = 1'b0;
            5'h0E: ef[6] = v[ix];
            5'h0F: ev[ix] = f[6];
            default: ;
        endcase
        if (op inside {[5'h06:5'h0A]}) begin
            ev = s[7:0];
            ef[3:0] = {s[7] ^ s[8], s[7], s[7:0] == 8'h00, s[8]};
        end
        if (tk) begin
            ep = p + {{9{k[6]}}, k} + 16'h0001;
            cy = 2;
        end
    endfunction

    task automatic run_one(input int i);
        logic [31:0] ins;
        logic [7:0]  f;
        logic [7:0]  v;
        logic [7:0]  ef;
        logic [7:0]  ev;
        logic [15:0] p;
        logic [15:0] ep;
        int          cy;
        int          ecy;
        ins = $urandom & 32'h000F_FFEF;
        // Now and then an opcode outside the decoded set, which must advance the PC and raise the illegal status bit.
        if (i % 25 == 24) ins[4] = 1'b1;
        if (i < 16) ins[14:0] = {7'h40, ins[7:5], i[4:0]};
        f = $urandom;
        v = $urandom;
        p = (i < 16) ? 16'h0020 : 16'($urandom);
        m.access(1'b1, ADR_OPERAND, {24'h0, v}, q);
        m.access(1'b1, ADR_FLAGS, {24'h0, f}, q);
        m.access(1'b1, ADR_PC, {16'h0, p}, q);
        m.access(1'b1, ADR_INSTR, ins, q);
        cy = 0;
        #1;
        while (busy === 1'b1 && cy < 8) begin
            @(posedge sysClk);
            #1;
            cy++;
        end
        predict(ins[4:0], ins[7:5], ins[14:8], f, v, p, ef, ev, ep, ecy);
        if (ins[4:1] == 4'h2) ioModel[ins[19:15]][ins[7:5]] = !ins[0];
        check(cy, ecy);
        check(pc, ep);
        check(flags, ef);
        m.access(1'b0, ADR_OPERAND, 32'h0, q);
        check(q, ev);
        m.access(1'b0, ADR_IO_BASE + {1'b0, ins[19:15], 2'h0}, 32'h0, q);
        check(q, ioModel[ins[19:15]]);
        m.access(1'b0, ADR_STATUS, 32'h0, q);
        check(q, {28'h0000000, ins[4], 1'b0, (ecy == 2 && ins[4:2] == 3'h0), 1'b0});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (ioModel[j]) ioModel[j] = 8'h00;
        nrst = 1'b0;
        void'($urandom(32'h668D079F));
        repeat (8) @(posedge sysClk);
        nrst <= 1'b1;
        check(flags, 8'h00);
        check(pc, 16'h0000);
        for (int i = 0; i < 300; i++) run_one(i);
        // A low clock enable must hold a started carry-set instruction where it stands.
        m.access(1'b1, ADR_PC, 32'h0000_0100, q);
        m.access(1'b1, ADR_INSTR, 32'h0000_000C, q);
        clkEn <= 1'b0;
        repeat (4) @(posedge sysClk);
        #1;
        check(busy, 1'b1);
        check(pc, 16'h0100);
        @(posedge sysClk);
        clkEn <= 1'b1;
        @(posedge sysClk);
        #1;
        check(busy, 1'b0);
        check(pc, 16'h0101);
        check(flags[0], 1'b1);
        // An unmapped address must read back as zero.
        m.access(1'b0, 8'h40, 32'h0, q);
        check(q, 32'h0);
        finish_test();
    end

    // A stuck handshake ends the run here; the busy wait is capped at 8 cycles.
    initial begin
        repeat (20000) @(posedge sysClk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
